// ==== spo_drv_model.sv ====
/* spo_drv_model: stand-in for the gate drivers and the a/d converter.
   assumes: pins and triggers are registered on clk_i by the timer. */
`timescale 1ns/1ps
// ----------------------------------------
// far side model
// ----------------------------------------
module spo_drv_model (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] out_pin_i, // gate drive levels
    input wire logic adc_trig_i,
    output logic [7:0] adc_cnt_o      // conversions started
);
    // one conversion per trigger pulse; a level would count every cycle
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) adc_cnt_o <= 8'h00;
        else if (adc_trig_i) adc_cnt_o <= adc_cnt_o + 8'h01;
    end
endmodule : spo_drv_model

// ==== spo_pkg.sv ====
/*
 * spo_pkg: register map, field positions, reset values and mode code
 * for the special pattern output timer block.
 * assumes: a 32-bit AHB-Lite register bus with one aligned word per register.
 */
package spo_pkg;
    // ------------------------------------------------------------
    // register byte offsets (low byte of haddr)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;   // timer_control_1 plus option bits
    localparam logic [7:0] ADDR_OUTCTL = 8'h04; // output_control_reg
    localparam logic [7:0] ADDR_ADCCTL = 8'h08; // option_reg_2 / option_reg_3
    localparam logic [7:0] ADDR_CMP0 = 8'h0c;   // compare_reg_0, next ones every 4 bytes
    localparam logic [7:0] ADDR_DT0 = 8'h24;    // dead_time_reg_0
    localparam logic [7:0] ADDR_DT1 = 8'h28;    // dead_time_reg_1
    localparam logic [7:0] ADDR_PATLO = 8'h2c;  // pattern_word_low
    localparam logic [7:0] ADDR_PATHI = 8'h30;  // pattern_word_high
    localparam logic [7:0] ADDR_STAT = 8'h34;   // status, flag is write-one-to-clear
    localparam logic [7:0] ADDR_STEP = 8'h04;   // spacing of compare registers
    // ------------------------------------------------------------
    // control word fields
    // ------------------------------------------------------------
    localparam int CTRL_RUN = 0;      // counter run bit
    localparam int CTRL_MODE_LSB = 1; // timer_mode_field, 4 bits
    localparam int CTRL_DTE = 8;      // dead_time_enable
    localparam int CTRL_EIE = 9;      // error_irq_enable
    localparam int CTRL_PIE = 10;     // peak_irq_enable
    localparam int CTRL_RFI = 11;     // reload_follows_irq
    localparam int CTRL_RTE = 12;     // reload_timing_enable
    localparam int CTRL_THIN_LSB = 16; // irq_thin_count, 5 bits
    // ------------------------------------------------------------
    // a/d trigger control fields (trigger 1 sits ADC1_OFS higher)
    // ------------------------------------------------------------
    localparam int ADC_PEAK = 0;      // peak source enable
    localparam int ADC_CMP4 = 1;      // compare 4 source enable
    localparam int ADC_CMP5 = 2;      // adc0/1_cmp5_source_enable
    localparam int ADC_THIN_LSB = 4;  // adc0/1_thin_select, 2 bits
    localparam int ADC1_OFS = 8;
    // ------------------------------------------------------------
    // status fields, mode code, reset values
    // ------------------------------------------------------------
    localparam int STAT_FLAG = 16;    // simultaneous_active_flag
    localparam int STAT_PIN_LSB = 24; // pin active states, before output enable and level select
    localparam logic [3:0] MODE_SPO = 4'hc;
    localparam logic [15:0] RST_CMP = 16'hffff;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
endpackage : spo_pkg

// ==== spo_timer.sv ====
/*
 * spo_timer: special pattern output mode of a motor-control timer, with an
 * AHB-Lite register slave, buffered reload, dead time, a/d triggers.
 * assumes: single clock ref_clk_i, hready_i tied to hreadyout_o of this slave,
 * the a/d converter and gate drivers sample the outputs on the same clock.
 */
`timescale 1ns/1ps
// Function
// - 16-bit sawtooth counter drives pins on compares
// - one nibble per pin, low then high word
// - mode active only for code 1100
// - compares 1 to 5 never clear counter
// - compare 0 match wraps counter to zero
// - compares 1 to 5 act on step to +1
// - settings buffered, reload armed by compare 1 write
// - one compare interrupt per compare 0 to 5
// - gated peak interrupt at compare 0, no trough
// - peak interrupt thinned by 5-bit count
// - trigger, event, overflow, trough, warning unused
// - error interrupt on simultaneous active, when enabled
// - per-pin level select and output enable
// - reload may follow thinned interrupt, needs enable
// - a/d triggers from compare 5, 4, peak
// - a/d triggers thinned 1 in 1,2,4,8
// - compare 0 cycle, 1-3 duty, pattern levels
// - dead time is count times clock period
// - dead time 0 after negative pin falls
// - dead time 1 after positive pin falls
// - positive pin wins simultaneous rise
// - dead time only when enabled
// - partner pin held inactive while one active
// - dead-time mode gives one-clock error pulse, flag
module spo_timer #(
    parameter int CNT_W = 16 // counter and compare width
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [7:0] out_pin_o,             // out_pin_0 .. out_pin_7
    output logic [5:0] compare_match_irq_o,   // one-clock pulses
    output logic peak_irq_o,
    output logic error_irq_o,
    output logic adc_trigger_0_o,
    output logic adc_trigger_1_o
);
    // external trigger / event inputs and overflow, trough, warning irqs have no port here

    if (CNT_W < 2 || CNT_W > 16) begin : g_chk
        $error("spo_timer: CNT_W must lie in 2..16");
    end

    // ------------------------------------------------------------
    // bus slave: address phase capture
    // ------------------------------------------------------------
    logic acc_w;          // valid transfer seen this cycle
    logic map_w;          // upper address bits are zero
    logic wr_pend_q;      // write data phase pending
    logic rd_pend_q;      // read wait state pending
    logic [7:0] addr_q;   // captured low address byte
    logic hready_q;
    logic [31:0] rdata_q;
    logic [31:0] rd_mux;

    assign acc_w = hsel_i && hready_i && htrans_i[1];
    assign map_w = (haddr_i[31:8] == 24'h000000);

    // writes finish with no wait; reads take one wait state so that a read
    // right after a write sees the written value
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
            hready_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wr_pend_q <= acc_w && hwrite_i && map_w && (hsize_i == 3'b010);
            rd_pend_q <= acc_w && !hwrite_i;
            if (acc_w) begin
                addr_q <= map_w ? haddr_i[7:0] : 8'hff;
            end
            hready_q <= !(acc_w && !hwrite_i);
            if (rd_pend_q) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign hrdata_o = rdata_q;
    assign hreadyout_o = hready_q;
    assign hresp_o = 1'b0; // always OKAY

    // ------------------------------------------------------------
    // register storage (shadow side written by software)
    // ------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [15:0] outctl_q;              // [7:0] pin_level_select, [15:8] pin_output_enable
    logic [15:0] adcctl_q;
    logic [CNT_W-1:0] cmp_s_q [6];      // compare shadows
    logic [CNT_W-1:0] cmp_b_q [6];      // compare buffers used by logic
    logic [CNT_W-1:0] dt_s_q [2];
    logic [CNT_W-1:0] dt_b_q [2];
    logic [31:0] pat_s_q;               // {pattern_word_high, pattern_word_low}
    logic [31:0] pat_b_q;
    logic flag_q;                       // simultaneous_active_flag
    logic pend_q;                       // reload armed by compare 1 write
    logic [5:0] wr_cmp;
    logic [CNT_W-1:0] cnt_q;
    logic [7:0] pin_act;

    genvar gk;
    for (gk = 0; gk < 6; gk++) begin : g_wdec
        assign wr_cmp[gk] = wr_pend_q && (addr_q == ADDR_CMP0_K(gk));
    end

    function automatic logic [7:0] ADDR_CMP0_K(input int k);
        ADDR_CMP0_K = spo_pkg::ADDR_CMP0 + 8'(k) * spo_pkg::ADDR_STEP;
    endfunction : ADDR_CMP0_K

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        for (int k = 0; k < 6; k++) begin
            if (addr_q == ADDR_CMP0_K(k)) begin
                rd_mux = 32'(cmp_s_q[k]);
            end
        end
        case (addr_q)
            spo_pkg::ADDR_CTRL: rd_mux = ctrl_q;
            spo_pkg::ADDR_OUTCTL: rd_mux = {16'h0000, outctl_q};
            spo_pkg::ADDR_ADCCTL: rd_mux = {16'h0000, adcctl_q};
            spo_pkg::ADDR_DT0: rd_mux = 32'(dt_s_q[0]);
            spo_pkg::ADDR_DT1: rd_mux = 32'(dt_s_q[1]);
            spo_pkg::ADDR_PATLO: rd_mux = {16'h0000, pat_s_q[15:0]};
            spo_pkg::ADDR_PATHI: rd_mux = {16'h0000, pat_s_q[31:16]};
            spo_pkg::ADDR_STAT: rd_mux = {pin_act, 7'h00, flag_q, 16'(cnt_q)};
            default: ;
        endcase
    end

    // control fields
    logic running;
    logic dte;
    logic eie;
    logic [4:0] thin_lim;
    assign running = ctrl_q[spo_pkg::CTRL_RUN] &&
                     (ctrl_q[spo_pkg::CTRL_MODE_LSB +: 4] == spo_pkg::MODE_SPO);
    assign dte = ctrl_q[spo_pkg::CTRL_DTE];
    assign eie = ctrl_q[spo_pkg::CTRL_EIE];
    assign thin_lim = ctrl_q[spo_pkg::CTRL_THIN_LSB +: 5];

    // ------------------------------------------------------------
    // counter and compare matches
    // ------------------------------------------------------------
    logic wrap;
    logic [5:0] match;
    logic [CNT_W-1:0] cnt_d;
    assign wrap = (cnt_q == cmp_b_q[0]);
    assign match[0] = running && wrap;
    for (gk = 1; gk < 6; gk++) begin : g_match
        // fires on the step from the compare value to value+1
        assign match[gk] = running && !wrap && (cnt_q == cmp_b_q[gk]);
    end
    // only compare 0 wraps; other matches leave the count running
    assign cnt_d = !running ? '0 : (wrap ? '0 : cnt_q + 1'b1);

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------
    // peak thinning and reload timing
    // ------------------------------------------------------------
    logic [4:0] pthin_q;
    logic peak_pass;
    logic reload_tick;
    logic load_now;
    assign peak_pass = match[0] && (pthin_q == 5'h00); // one peak in thin_lim+1
    assign reload_tick = match[0] && ctrl_q[spo_pkg::CTRL_RTE] &&
                         (!ctrl_q[spo_pkg::CTRL_RFI] || peak_pass);
    // while stopped, buffers track shadows so the first cycle uses fresh values
    assign load_now = !running || (reload_tick && pend_q);

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pthin_q <= 5'h00;
        end else if (!running) begin
            pthin_q <= 5'h00;
        end else if (match[0]) begin
            pthin_q <= (pthin_q >= thin_lim) ? 5'h00 : pthin_q + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // software writes and buffered reload
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_q <= spo_pkg::RST_CTRL;
            outctl_q <= spo_pkg::RST_ZERO;
            adcctl_q <= spo_pkg::RST_ZERO;
            pat_s_q <= {spo_pkg::RST_ZERO, spo_pkg::RST_ZERO};
            pat_b_q <= {spo_pkg::RST_ZERO, spo_pkg::RST_ZERO};
            pend_q <= 1'b0;
            for (int k = 0; k < 6; k++) begin
                cmp_s_q[k] <= spo_pkg::RST_CMP[CNT_W-1:0];
                cmp_b_q[k] <= spo_pkg::RST_CMP[CNT_W-1:0];
            end
            for (int k = 0; k < 2; k++) begin
                dt_s_q[k] <= spo_pkg::RST_ZERO[CNT_W-1:0];
                dt_b_q[k] <= spo_pkg::RST_ZERO[CNT_W-1:0];
            end
        end else begin
            if (wr_pend_q) begin
                case (addr_q)
                    spo_pkg::ADDR_CTRL: ctrl_q <= hwdata_i;
                    spo_pkg::ADDR_OUTCTL: outctl_q <= hwdata_i[15:0];
                    spo_pkg::ADDR_ADCCTL: adcctl_q <= hwdata_i[15:0];
                    spo_pkg::ADDR_DT0: dt_s_q[0] <= hwdata_i[CNT_W-1:0];
                    spo_pkg::ADDR_DT1: dt_s_q[1] <= hwdata_i[CNT_W-1:0];
                    spo_pkg::ADDR_PATLO: pat_s_q[15:0] <= hwdata_i[15:0];
                    spo_pkg::ADDR_PATHI: pat_s_q[31:16] <= hwdata_i[15:0];
                    default: ;
                endcase
            end
            for (int k = 0; k < 6; k++) begin
                if (wr_cmp[k]) begin
                    cmp_s_q[k] <= hwdata_i[CNT_W-1:0];
                end
            end
            // a compare 1 write arms reload; arming wins over consuming
            pend_q <= wr_cmp[1] || (pend_q && !(reload_tick && running));
            // buffers copy whole shadows at once, so a cycle never mixes settings
            if (load_now) begin
                pat_b_q <= pat_s_q;
                for (int k = 0; k < 6; k++) begin
                    cmp_b_q[k] <= cmp_s_q[k];
                end
                for (int k = 0; k < 2; k++) begin
                    dt_b_q[k] <= dt_s_q[k];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // pattern requests: pin p takes nibble p, bit k after match k
    // ------------------------------------------------------------
    logic [7:0] raw_q;
    logic [7:0] raw_d;
    always_comb begin
        raw_d = raw_q;
        for (int k = 0; k < 4; k++) begin
            for (int p = 0; p < 8; p++) begin
                if (match[k]) begin
                    raw_d[p] = pat_b_q[p*4 + k];
                end
            end
        end
        if (!running) begin
            raw_d = 8'h00;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            raw_q <= 8'h00;
        end else begin
            raw_q <= raw_d;
        end
    end

    // ------------------------------------------------------------
    // complementary pairs 1/2, 3/4, 5/6 with dead time and priority
    // ------------------------------------------------------------
    logic [2:0] sim_new; // both set conditions appear this cycle
    logic [2:0] sim_lvl; // both requests stand together
    assign pin_act[0] = raw_q[0]; // edge pins have no dead time
    assign pin_act[7] = raw_q[7];

    for (gk = 0; gk < 3; gk++) begin : g_pair
        localparam int PP = 2*gk + 1; // positive phase pin
        localparam int NP = 2*gk + 2; // negative phase pin
        logic pos_q;
        logic neg_q;
        logic pos_d;
        logic neg_d;
        logic busy;
        logic [CNT_W-1:0] dt_q;
        logic [CNT_W-1:0] dt_d;
        // a delay of D holds the partner off for D clocks
        assign busy = dte && (dt_q > 1);
        // an active pin holds its partner off; positive wins a tie
        assign pos_d = pos_q ? raw_q[PP] : (!neg_q && !busy && raw_q[PP]);
        assign neg_d = neg_q ? raw_q[NP] : (!pos_q && !busy && raw_q[NP] && !raw_q[PP]);
        assign dt_d = (pos_q && !pos_d) ? dt_b_q[1] :
                      (neg_q && !neg_d) ? dt_b_q[0] :
                      ((dt_q != '0) ? dt_q - 1'b1 : dt_q);
        assign sim_new[gk] = raw_d[PP] && raw_d[NP] && !(raw_q[PP] && raw_q[NP]);
        assign sim_lvl[gk] = raw_q[PP] && raw_q[NP];
        assign pin_act[PP] = pos_q;
        assign pin_act[NP] = neg_q;

        always_ff @(posedge ref_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                pos_q <= 1'b0;
                neg_q <= 1'b0;
                dt_q <= '0;
            end else begin
                pos_q <= pos_d;
                neg_q <= neg_d;
                dt_q <= dt_d;
            end
        end

        excl_pair_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
            !(pos_q && neg_q)) else $error("both phases of a pair active");
        dead_gap_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
            $fell(pos_q) && dte && dt_q > 1 |-> !neg_q ##1 !neg_q) else $error("dead time violated");
        pos_wins_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
            !pos_q && !neg_q && !busy && raw_q[PP] && raw_q[NP] |=> pos_q && !neg_q)
            else $error("positive phase lost simultaneous rise");
    end

    // ------------------------------------------------------------
    // outputs: interrupts, error detection, pins
    // ------------------------------------------------------------
    logic [5:0] cmp_irq_q;
    logic peak_q;
    logic err_q;
    logic err_d;
    logic [7:0] pin_q;
    logic [7:0] pin_d;
    // with dead time: one-clock pulse at the set; without: level while both stand
    assign err_d = eie && (dte ? |sim_new : |sim_lvl);
    // disabled pins sit at the inactive level
    assign pin_d = (pin_act & outctl_q[15:8]) ^ outctl_q[7:0];

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmp_irq_q <= 6'h00;
            peak_q <= 1'b0;
            err_q <= 1'b0;
            flag_q <= 1'b0;
            pin_q <= 8'h00;
        end else begin
            cmp_irq_q <= match;
            peak_q <= peak_pass && ctrl_q[spo_pkg::CTRL_PIE];
            err_q <= err_d;
            // a new detection wins over a software clear
            flag_q <= (dte ? |sim_new : |sim_lvl) ||
                      (flag_q && !(wr_pend_q && addr_q == spo_pkg::ADDR_STAT &&
                                   hwdata_i[spo_pkg::STAT_FLAG]));
            pin_q <= pin_d;
        end
    end

    assign compare_match_irq_o = cmp_irq_q;
    assign peak_irq_o = peak_q;
    assign error_irq_o = err_q;
    assign out_pin_o = pin_q;

    // ------------------------------------------------------------
    // a/d triggers with thinning
    // ------------------------------------------------------------
    logic [1:0] adc_q;
    for (gk = 0; gk < 2; gk++) begin : g_adc
        logic [7:0] fld;
        logic ev;
        logic [2:0] lim;
        logic [2:0] tc_q;
        assign fld = adcctl_q[gk*spo_pkg::ADC1_OFS +: 8];
        assign ev = (fld[spo_pkg::ADC_PEAK] && peak_pass) ||
                    (fld[spo_pkg::ADC_CMP4] && match[4]) ||
                    (fld[spo_pkg::ADC_CMP5] && match[5]);
        // select 0..3 passes one event in 1, 2, 4 or 8
        assign lim = 3'((4'h1 << fld[spo_pkg::ADC_THIN_LSB +: 2]) - 4'h1);

        always_ff @(posedge ref_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                tc_q <= 3'h0;
                adc_q[gk] <= 1'b0;
            end else begin
                adc_q[gk] <= ev && (tc_q == 3'h0);
                if (!running) begin
                    tc_q <= 3'h0;
                end else if (ev) begin
                    tc_q <= (tc_q >= lim) ? 3'h0 : tc_q + 3'h1;
                end
            end
        end
    end
    assign adc_trigger_0_o = adc_q[0];
    assign adc_trigger_1_o = adc_q[1];

    // ------------------------------------------------------------
    // checks on the timer core
    // ------------------------------------------------------------
    wrap_zero_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        match[0] && running |=> cnt_q == '0) else $error("counter did not wrap at compare 0");
    keep_count_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (|match[5:1]) && running |=> cnt_q == $past(cnt_q) + 1'b1) else $error("counter cleared by compare");
    mode_stop_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !running |=> cnt_q == '0 && raw_q == 8'h00) else $error("counter ran outside mode");
    pat_level_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        match[2] && running |=> raw_q[5] == $past(pat_b_q[22])) else $error("pin 5 missed pattern bit");
    peak_gate_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        peak_irq_o |-> $past(match[0]) && $past(ctrl_q[spo_pkg::CTRL_PIE])) else $error("peak irq without cause");
    err_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        error_irq_o && $past(dte) |-> flag_q && $past(eie)) else $error("error pulse without flag or enable");
    reload_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        running && !(reload_tick && pend_q) |=> cmp_b_q[1] == $past(cmp_b_q[1]))
        else $error("buffer changed outside reload");
    pin_off_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !outctl_q[8] |=> out_pin_o[0] == $past(outctl_q[0])) else $error("disabled pin not inactive");

    cov_reload_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) reload_tick && pend_q);
    cov_err_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) error_irq_o && dte);
    cov_adc_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) adc_trigger_1_o && match[5]);
endmodule : spo_timer

// ==== tb_spo_timer.sv ====
/* tb_spo_timer: register and pattern tests of the timer.
   assumes: spo_pkg and spo_drv_model compiled first. */
`timescale 1ns/1ps
// ----------------------------------------
// bench
// ----------------------------------------
module tb_spo_timer;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rd;
    wire [31:0] hrdata;
    wire hready;
    wire [7:0] pins;
    wire [5:0] cmi;
    wire peak, err, adc0, adc1;
    wire [7:0] adc_cnt;
    int error_cnt = 0;
    int checks_done = 0;
    int n;
    // 200 mhz clock
    initial forever #2.5 clk = ~clk;
    spo_timer dut (.ref_clk_i(clk), .resetn_i(rst_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(), .out_pin_o(pins), .compare_match_irq_o(cmi), .peak_irq_o(peak),
        .error_irq_o(err), .adc_trigger_0_o(adc0), .adc_trigger_1_o(adc1));
    spo_drv_model gate (.clk_i(clk), .resetn_i(rst_n), .out_pin_i(pins), .adc_trig_i(adc0), .adc_cnt_o(adc_cnt));
    // one single ahb-lite transfer, address phase held until hready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask : bus
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // wait for compare k pulse, n counts edges waited
    task automatic wt(input int k);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (cmi[k] !== 1'b1);
    endtask : wt
    task automatic final_report;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, spo_pkg::ADDR_CMP0, 32'h0);
        chk("cmp0 reset", 32'hffff, rd);
        bus(1'b0, 8'h38, 32'h0);
        chk("unmapped read", 32'h0, rd);
        // run bit with a foreign mode code must not count
        bus(1'b1, spo_pkg::ADDR_CTRL, 32'h1);
        repeat (20) @(posedge clk);
        bus(1'b0, spo_pkg::ADDR_STAT, 32'h0);
        chk("idle counter", 32'h0, rd & 32'hffff);
        bus(1'b1, spo_pkg::ADDR_CTRL, 32'h0);
        bus(1'b1, spo_pkg::ADDR_CMP0, 32'h9);
        bus(1'b1, spo_pkg::ADDR_CMP0 + 8'h08, 32'h4);
        bus(1'b1, spo_pkg::ADDR_CMP0 + 8'h0c, 32'h6);
        bus(1'b1, spo_pkg::ADDR_PATLO, 32'h5);
        bus(1'b1, spo_pkg::ADDR_OUTCTL, 32'h100);
        bus(1'b1, spo_pkg::ADDR_ADCCTL, 32'h11);
        bus(1'b1, spo_pkg::ADDR_CMP0 + 8'h04, 32'h2);
        bus(1'b1, spo_pkg::ADDR_CTRL, 32'h419);
        // peak source thinned to one in two: 4 peaks give 2 conversions
        for (int i = 0; i < 4; i++) wt(0);
        repeat (3) @(posedge clk);
        chk("adc conversions", 32'h2, {24'h0, adc_cnt});
        wt(0);
        chk("peak irq", 32'h1, {31'h0, peak});
        wt(0);
        chk("period", 32'd10, n);
        for (int k = 1; k < 5; k++) begin
            wt(k % 4);
            if (k == 1) chk("cmp1 delay", 32'd3, n);
            @(posedge clk);
            #1;
            chk("pin 0 level", 32'((4'h5 >> (k % 4)) & 4'h1), {31'h0, pins[0]});
        end
        // pins 5 and 6 both set at compare 0, dead time off: positive wins, error level stands
        bus(1'b1, spo_pkg::ADDR_PATHI, 32'h0110);
        bus(1'b1, spo_pkg::ADDR_OUTCTL, 32'h6100);
        bus(1'b1, spo_pkg::ADDR_CTRL, 32'h1619);
        bus(1'b1, spo_pkg::ADDR_CMP0 + 8'h04, 32'h2);
        wt(0);
        wt(0);
        repeat (2) @(posedge clk);
        #1;
        chk("pins 6..5", 32'h1, {30'h0, pins[6:5]});
        chk("error irq", 32'h1, {31'h0, err});
        chk("adc trigger 1", 32'h0, {31'h0, adc1});
        bus(1'b0, spo_pkg::ADDR_STAT, 32'h0);
        chk("sim flag", 32'h1, (rd >> spo_pkg::STAT_FLAG) & 32'h1);
        final_report();
    end
    // watchdog against a hung handshake
    initial begin
        #20000;
        error_cnt++;
        final_report();
    end
endmodule : tb_spo_timer
